// ===== via_pkg.sv
package via_pkg;
   // apb register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_BASE = 8'h08;
   localparam logic [7:0] OFS_VCOUNT = 8'h0c;
   localparam logic [7:0] OFS_ICOUNT = 8'h10;
   localparam logic [7:0] OFS_IDXBASE = 8'h14;
   localparam logic [7:0] OFS_ARRBASE0 = 8'h18;
   localparam logic [7:0] OFS_MAXIDX0 = 8'h20;
   localparam logic [7:0] OFS_ELEM0 = 8'h28;
   localparam logic [7:0] OFS_CMD = 8'h38;
   localparam logic [7:0] OFS_STATUS = 8'h3c;
   // ctrl fields
   localparam int CTRL_CACHE_EN = 0;
   localparam int CTRL_RANDOM = 1;
   localparam int CTRL_CUT_EN = 2;
   localparam int CTRL_IW_LO = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [1:0] IW_8 = 2'h0;
   localparam logic [1:0] IW_16 = 2'h1;
   // cmd fields
   localparam int CMD_GO = 0;
   localparam int CMD_INV = 1;
   // element descriptor fields
   localparam int EL_VALID = 0;
   localparam int EL_ARR = 1;
   localparam int EL_INST = 2;
   localparam int EL_DST_LO = 4;
   localparam int EL_SRC_LO = 8;
   localparam int EL_CC_LO = 16;
   localparam int EL_FMT = 28;
   // component controls
   localparam logic [2:0] CC_SRC = 3'h0;
   localparam logic [2:0] CC_ZERO = 3'h1;
   localparam logic [2:0] CC_ONE_INT = 3'h2;
   localparam logic [2:0] CC_ONE_FLT = 3'h3;
   localparam logic [2:0] CC_VTX_ORD = 3'h4;
   localparam logic [2:0] CC_COPY_ORD = 3'h5;
   localparam logic [2:0] CC_OBJ_ORD = 3'h6;
   localparam logic [2:0] CC_STOP = 3'h7;
   localparam logic [31:0] ONE_INT = 32'h0000_0001;
   localparam logic [31:0] ONE_FLT = 32'h3f80_0000;
   // sizes
   localparam int NUM_EL = 4;
   localparam int NUM_ARR = 2;
   localparam int NUM_COMP = 4;
   localparam int CACHE_N = 4;
   localparam int HANDLE_W = 8;
   localparam int DW_W = 6;
   localparam logic [31:0] PITCH_DW = 32'h0000_0004;
   typedef enum {S_IDLE, S_INST, S_VTX, S_IDXW, S_LOOK, S_COMP, S_MEMW, S_EMIT, S_CUT}
      via_state_t;
endpackage

// ===== via_top.sv
`timescale 1ns/10ps
`default_nettype none
module via_top
   import via_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // memory read port (dword addresses)
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_rvalid,
   input wire logic [31:0] mem_rdata,
   // storage entry write port
   output logic vse_wr_valid,
   output logic [HANDLE_W-1:0] vse_wr_handle,
   output logic [DW_W-1:0] vse_wr_dword,
   output logic [31:0] vse_wr_data,
   // handle stream to the shading stage
   output logic out_valid,
   input wire logic out_ready,
   output logic [HANDLE_W-1:0] out_handle,
   output logic out_reuse,
   output logic out_cut,
   output logic [31:0] out_object
);
   logic [31:0] ctrl, start_loc, base_vtx, vcount, icount, idx_base;
   logic [31:0] arr_base [NUM_ARR];
   logic [31:0] max_idx [NUM_ARR];
   logic [31:0] elem [NUM_EL];
   logic [15:0] hit_count;
   via_state_t st;
   logic [31:0] vnum, inum, fetch_tag, vert_ord, copy_ord, obj_ord;
   logic [1:0] el, comp;
   logic inst_end;
   logic [HANDLE_W-1:0] cur_handle, next_handle;
   logic c_valid [CACHE_N];
   logic [31:0] c_tag [CACHE_N];
   logic [HANDLE_W-1:0] c_handle [CACHE_N];
   logic [1:0] c_ptr;
   logic apb_wr, cfg_wr, go, inv_cmd, inst_inv, inv, ins;
   logic hit;
   logic [HANDLE_W-1:0] hit_handle;
   logic [31:0] d, sel_idx, const_data, idx_val, all_ones, conv;
   logic [2:0] cc;
   logic skip, oob, step_end, any_inst;

   // apb slave: zero-wait access phase, unmapped addresses answer with pslverr
   assign apb_wr = psel && penable && pready && pwrite;
   assign go = apb_wr && paddr == OFS_CMD && pwdata[CMD_GO];
   assign inv_cmd = apb_wr && paddr == OFS_CMD && pwdata[CMD_INV];
   assign cfg_wr = apb_wr && paddr < OFS_CMD;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable)
         begin
            unique case (paddr)
               OFS_CTRL: prdata <= ctrl;
               OFS_START: prdata <= start_loc;
               OFS_BASE: prdata <= base_vtx;
               OFS_VCOUNT: prdata <= vcount;
               OFS_ICOUNT: prdata <= icount;
               OFS_IDXBASE: prdata <= idx_base;
               OFS_ARRBASE0: prdata <= arr_base[0];
               OFS_ARRBASE0 + 8'h04: prdata <= arr_base[1];
               OFS_MAXIDX0: prdata <= max_idx[0];
               OFS_MAXIDX0 + 8'h04: prdata <= max_idx[1];
               OFS_ELEM0: prdata <= elem[0];
               OFS_ELEM0 + 8'h04: prdata <= elem[1];
               OFS_ELEM0 + 8'h08: prdata <= elem[2];
               OFS_ELEM0 + 8'h0c: prdata <= elem[3];
               OFS_CMD: prdata <= 32'h0;
               OFS_STATUS: prdata <= {hit_count, 15'h0, st != S_IDLE};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl <= CTRL_RESET;
         start_loc <= 32'h0;
         base_vtx <= 32'h0;
         vcount <= 32'h0;
         icount <= 32'h0;
         idx_base <= 32'h0;
         for (int i = 0; i < NUM_ARR; i++)
         begin
            arr_base[i] <= 32'h0;
            max_idx[i] <= 32'h0;
         end
         for (int i = 0; i < NUM_EL; i++)
            elem[i] <= 32'h0;
      end
      else if (apb_wr)
      begin
         unique case (paddr)
            OFS_CTRL: ctrl <= pwdata;
            OFS_START: start_loc <= pwdata;
            OFS_BASE: base_vtx <= pwdata;
            OFS_VCOUNT: vcount <= pwdata;
            OFS_ICOUNT: icount <= pwdata;
            OFS_IDXBASE: idx_base <= pwdata;
            OFS_ARRBASE0: arr_base[0] <= pwdata;
            OFS_ARRBASE0 + 8'h04: arr_base[1] <= pwdata;
            OFS_MAXIDX0: max_idx[0] <= pwdata;
            OFS_MAXIDX0 + 8'h04: max_idx[1] <= pwdata;
            OFS_ELEM0: elem[0] <= pwdata;
            OFS_ELEM0 + 8'h04: elem[1] <= pwdata;
            OFS_ELEM0 + 8'h08: elem[2] <= pwdata;
            OFS_ELEM0 + 8'h0c: elem[3] <= pwdata;
            default: ;
         endcase
      end
   end

   // descriptor decode for the current element and component
   always_comb
   begin
      d = elem[el];
      cc = d[EL_CC_LO + 3 * comp +: 3];
      skip = !d[EL_VALID] || cc == CC_STOP;
      sel_idx = d[EL_INST] ? copy_ord : fetch_tag;
      oob = sel_idx[31] || sel_idx > max_idx[d[EL_ARR]];
      step_end = skip || comp == 2'(NUM_COMP - 1);
      unique case (cc)
         CC_ONE_INT: const_data = ONE_INT;
         CC_ONE_FLT: const_data = ONE_FLT;
         CC_VTX_ORD: const_data = vert_ord;
         CC_COPY_ORD: const_data = copy_ord;
         CC_OBJ_ORD: const_data = obj_ord;
         default: const_data = 32'h0;
      endcase
      conv = d[EL_FMT] ? {24'h0, mem_rdata[7:0]} : mem_rdata;
      unique case (ctrl[CTRL_IW_LO +: 2])
         IW_8: all_ones = 32'h0000_00ff;
         IW_16: all_ones = 32'h0000_ffff;
         default: all_ones = 32'hffff_ffff;
      endcase
      idx_val = mem_rdata & all_ones;
      any_inst = 1'b0;
      for (int i = 0; i < NUM_EL; i++)
         any_inst = any_inst || (elem[i][EL_VALID] && elem[i][EL_INST]);
   end

   // between instances the copy index changes but the tag does not
   assign inst_inv = st == S_INST && inum != 32'h0 && any_inst;
   assign inv = inv_cmd || cfg_wr || inst_inv;
   assign ins = ctrl[CTRL_CACHE_EN] && el == 2'(NUM_EL - 1) &&
      ((st == S_COMP && skip) || (st == S_MEMW && mem_rvalid && step_end) ||
       (st == S_COMP && !skip && !(cc == CC_SRC && !oob) && step_end));

   // fully associative tag lookup
   always_comb
   begin
      hit = 1'b0;
      hit_handle = '0;
      for (int i = 0; i < CACHE_N; i++)
      begin
         if (c_valid[i] && c_tag[i] == fetch_tag)
         begin
            hit = 1'b1;
            hit_handle = c_handle[i];
         end
      end
   end

   // fifo replacement; only handles are kept, the data lives in storage
   always_ff @(posedge clk)
   begin
      if (rst || inv)
      begin
         c_ptr <= 2'h0;
         for (int i = 0; i < CACHE_N; i++)
            c_valid[i] <= 1'b0;
      end
      else if (ins)
      begin
         c_valid[c_ptr] <= 1'b1;
         c_tag[c_ptr] <= fetch_tag;
         c_handle[c_ptr] <= cur_handle;
         c_ptr <= c_ptr + 2'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         hit_count <= 16'h0;
      else if (st == S_LOOK && ctrl[CTRL_CACHE_EN] && hit)
         hit_count <= hit_count + 16'h1;
   end

   // main sequencer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st <= S_IDLE;
         vnum <= 32'h0;
         inum <= 32'h0;
         fetch_tag <= 32'h0;
         vert_ord <= 32'h0;
         copy_ord <= 32'h0;
         obj_ord <= 32'h0;
         el <= 2'h0;
         comp <= 2'h0;
         inst_end <= 1'b0;
         cur_handle <= '0;
         next_handle <= '0;
         mem_req <= 1'b0;
         mem_addr <= 32'h0;
         vse_wr_valid <= 1'b0;
         vse_wr_handle <= '0;
         vse_wr_dword <= '0;
         vse_wr_data <= 32'h0;
         out_valid <= 1'b0;
         out_handle <= '0;
         out_reuse <= 1'b0;
         out_cut <= 1'b0;
         out_object <= 32'h0;
      end
      else
      begin
         vse_wr_valid <= 1'b0;
         unique case (st)
            S_IDLE:
            begin
               if (go)
               begin
                  inum <= 32'h0;
                  copy_ord <= 32'h0;
                  st <= S_INST;
               end
            end
            S_INST:
            begin
               vnum <= 32'h0;
               obj_ord <= 32'h0;
               st <= (inum == icount) ? S_IDLE : S_VTX;
            end
            S_VTX:
            begin
               if (vnum == vcount)
               begin
                  inst_end <= 1'b1;
                  st <= S_CUT;
               end
               else if (ctrl[CTRL_RANDOM])
               begin
                  mem_req <= 1'b1;
                  mem_addr <= idx_base + start_loc + vnum;
                  st <= S_IDXW;
               end
               else
               begin
                  fetch_tag <= start_loc + vnum;
                  vert_ord <= vnum;
                  st <= S_LOOK;
               end
            end
            S_IDXW:
            begin
               if (mem_rvalid)
               begin
                  mem_req <= 1'b0;
                  if (ctrl[CTRL_CUT_EN] && idx_val == all_ones)
                  begin
                     inst_end <= 1'b0;
                     st <= S_CUT;
                  end
                  else
                  begin
                     vert_ord <= idx_val;
                     fetch_tag <= idx_val + base_vtx;
                     st <= S_LOOK;
                  end
               end
            end
            S_LOOK:
            begin
               out_object <= obj_ord;
               out_cut <= 1'b0;
               if (ctrl[CTRL_CACHE_EN] && hit)
               begin
                  out_handle <= hit_handle;
                  out_reuse <= 1'b1;
                  out_valid <= 1'b1;
                  st <= S_EMIT;
               end
               else
               begin
                  cur_handle <= next_handle;
                  next_handle <= next_handle + 1'b1;
                  el <= 2'h0;
                  comp <= 2'h0;
                  st <= S_COMP;
               end
            end
            S_COMP, S_MEMW:
            begin
               if (st == S_COMP && !skip && cc == CC_SRC && !oob)
               begin
                  mem_req <= 1'b1;
                  mem_addr <= arr_base[d[EL_ARR]] + sel_idx * PITCH_DW
                     + {24'h0, d[EL_SRC_LO +: 8]};
                  st <= S_MEMW;
               end
               else if (st == S_COMP || mem_rvalid)
               begin
                  mem_req <= 1'b0;
                  if (st == S_MEMW || !skip)
                  begin
                     vse_wr_valid <= 1'b1;
                     vse_wr_handle <= cur_handle;
                     vse_wr_dword <= DW_W'(d[EL_DST_LO +: 4]) + DW_W'(comp);
                     vse_wr_data <= (st == S_MEMW) ? conv : const_data;
                  end
                  if (step_end)
                  begin
                     comp <= 2'h0;
                     el <= el + 2'h1;
                     if (el == 2'(NUM_EL - 1))
                     begin
                        out_handle <= cur_handle;
                        out_reuse <= 1'b0;
                        out_valid <= 1'b1;
                        st <= S_EMIT;
                     end
                     else
                        st <= S_COMP;
                  end
                  else
                  begin
                     comp <= comp + 2'h1;
                     st <= S_COMP;
                  end
               end
            end
            S_EMIT:
            begin
               if (out_ready)
               begin
                  out_valid <= 1'b0;
                  vnum <= vnum + 32'h1;
                  st <= S_VTX;
               end
            end
            S_CUT:
            begin
               if (!out_valid)
               begin
                  out_valid <= 1'b1;
                  out_cut <= 1'b1;
                  out_reuse <= 1'b0;
                  out_object <= obj_ord;
               end
               else if (out_ready)
               begin
                  out_valid <= 1'b0;
                  out_cut <= 1'b0;
                  obj_ord <= obj_ord + 32'h1;
                  if (inst_end)
                  begin
                     inst_end <= 1'b0;
                     inum <= inum + 32'h1;
                     copy_ord <= copy_ord + 32'h1;
                     st <= S_INST;
                  end
                  else
                  begin
                     vnum <= vnum + 32'h1;
                     st <= S_VTX;
                  end
               end
            end
         endcase
      end
   end

   // checks
   property p_hold;
      @(posedge clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_handle) && $stable(out_cut);
   endproperty
   a_hold: assert property (p_hold) else $error("handle dropped before ready");

   sequence s_hit_look;
      st == S_LOOK && ctrl[CTRL_CACHE_EN] && hit;
   endsequence
   property p_hit;
      @(posedge clk) disable iff (rst)
      s_hit_look |=> st == S_EMIT && out_reuse && out_valid;
   endproperty
   a_hit: assert property (p_hit) else $error("hit not forwarded as reuse");

   property p_miss;
      @(posedge clk) disable iff (rst)
      st == S_LOOK && !(ctrl[CTRL_CACHE_EN] && hit) |=> st == S_COMP && !out_valid;
   endproperty
   a_miss: assert property (p_miss) else $error("miss did not start assembly");

   property p_oob;
      @(posedge clk) disable iff (rst)
      st == S_COMP && !skip && cc == CC_SRC && oob |=> !mem_req && vse_wr_data == 32'h0;
   endproperty
   a_oob: assert property (p_oob) else $error("out of range index read memory");

   property p_seq;
      @(posedge clk) disable iff (rst)
      st == S_VTX && !ctrl[CTRL_RANDOM] && vnum != vcount
      |=> fetch_tag == $past(start_loc) + $past(vnum) && vert_ord == $past(vnum);
   endproperty
   a_seq: assert property (p_seq) else $error("sequential tag wrong");

   property p_inv;
      @(posedge clk) disable iff (rst)
      inv |=> !c_valid[0] && !c_valid[1] && !c_valid[2] && !c_valid[3];
   endproperty
   a_inv: assert property (p_inv) else $error("cache not cleared");

   property p_cut;
      @(posedge clk) disable iff (rst)
      st == S_IDXW && mem_rvalid && ctrl[CTRL_CUT_EN] && idx_val == all_ones
      |=> st == S_CUT ##1 out_valid && out_cut;
   endproperty
   a_cut: assert property (p_cut) else $error("cut index not honoured");

   property p_dword;
      @(posedge clk) disable iff (rst)
      vse_wr_valid |-> vse_wr_dword >= DW_W'($past(d[EL_DST_LO +: 4]))
         && vse_wr_dword < DW_W'($past(d[EL_DST_LO +: 4])) + DW_W'(NUM_COMP);
   endproperty
   a_dword: assert property (p_dword) else $error("write outside element dwords");
endmodule
`default_nettype wire

// ===== via_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module via_mem_model
   import via_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // memory read port
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_rvalid,
   output logic [31:0] mem_rdata,
   // handle stream
   output logic out_ready
);
   logic [31:0] mem [256];
   logic [1:0] cnt;
   logic slow;
   logic [2:0] pace;
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 32'h5a00_0000 | 32'(i);
   end
   // idle data toggles so a stale word is never mistaken for an answer
   always_ff @(posedge clk)
   begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (rst)
      begin
         cnt <= 2'h0;
         slow <= 1'b0;
         mem_rdata <= 32'h0;
      end
      else if (mem_req && !mem_rvalid)
      begin
         if (cnt == (slow ? 2'h3 : 2'h0))
         begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            cnt <= 2'h0;
            slow <= ~slow;
         end
         else
            cnt <= cnt + 2'h1;
      end
   end
   // one stall cycle in four keeps back-pressure on the handle stream
   always_ff @(posedge clk)
      pace <= rst ? 3'h0 : pace + 3'h1;
   assign out_ready = (pace[1:0] != 2'h2);
endmodule
`default_nettype wire

// ===== tb_via_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_via_top;
   import via_pkg::*;
   localparam logic [31:0] EL_A = 32'h111 |
      (32'({CC_ONE_FLT, CC_VTX_ORD, CC_ZERO, CC_SRC}) << EL_CC_LO);
   logic clk, rst, psel, penable, pwrite, pready, pslverr, mem_req, mem_rvalid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, mem_rdata, vse_wr_data, out_object;
   logic vse_wr_valid, out_valid, out_ready, out_reuse, out_cut;
   logic [HANDLE_W-1:0] vse_wr_handle, out_handle;
   logic [DW_W-1:0] vse_wr_dword;
   int errors, samples_checked;
   logic [31:0] wq_data[$], oq_obj[$];
   logic [DW_W-1:0] wq_dw[$];
   logic [HANDLE_W-1:0] wq_h[$], oq_h[$];
   logic oq_reuse[$], oq_cut[$];
   via_top i_via_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .vse_wr_valid(vse_wr_valid), .vse_wr_handle(vse_wr_handle), .vse_wr_dword(vse_wr_dword),
      .vse_wr_data(vse_wr_data), .out_valid(out_valid), .out_ready(out_ready),
      .out_handle(out_handle), .out_reuse(out_reuse), .out_cut(out_cut),
      .out_object(out_object));
   via_mem_model i_via_mem_model (.clk(clk), .rst(rst), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .out_ready(out_ready));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // sampled at the edge, before the design's updates land
   always @(posedge clk)
   begin
      if (vse_wr_valid === 1'b1)
      begin
         wq_dw.push_back(vse_wr_dword);
         wq_data.push_back(vse_wr_data);
         wq_h.push_back(vse_wr_handle);
      end
      if (out_valid === 1'b1 && out_ready === 1'b1)
      begin
         oq_h.push_back(out_handle);
         oq_reuse.push_back(out_reuse);
         oq_cut.push_back(out_cut);
         oq_obj.push_back(out_object);
      end
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // entered right after an edge; ends one edge after release
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         errors++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task draw(input int nout);
      logic [31:0] q;
      logic e;
      int n;
      wr(OFS_CMD, 32'h1);
      q = 32'h1;
      n = 0;
      while ((q[0] !== 1'b0 || oq_h.size() < nout) && n < 500)
      begin
         apb(1'b0, OFS_STATUS, 32'h0, q, e);
         n++;
      end
      chk("handle count", nout, oq_h.size());
      chk("busy", 32'h0, {31'h0, q[0]});
   endtask
   task pop_vtx(input logic [31:0] m, input logic [31:0] vord, input logic [31:0] obj,
      output logic [HANDLE_W-1:0] h);
      logic [31:0] exp [4];
      exp = '{m, 32'h0, vord, ONE_FLT};
      h = oq_h.pop_front();
      chk("reuse", 32'h0, oq_reuse.pop_front());
      chk("cut", 32'h0, oq_cut.pop_front());
      chk("object", obj, oq_obj.pop_front());
      for (int c = 0; c < 4; c++)
      begin
         chk("dword", 1 + c, wq_dw.pop_front());
         chk("data", exp[c], wq_data.pop_front());
         chk("entry", h, wq_h.pop_front());
      end
   endtask
   task pop_hit(input logic [HANDLE_W-1:0] h, input logic [31:0] obj);
      chk("hit handle", h, oq_h.pop_front());
      chk("hit reuse", 32'h1, oq_reuse.pop_front());
      chk("hit cut", 32'h0, oq_cut.pop_front());
      chk("hit object", obj, oq_obj.pop_front());
   endtask
   task pop_cut();
      void'(oq_h.pop_front());
      void'(oq_reuse.pop_front());
      void'(oq_obj.pop_front());
      chk("cut token", 32'h1, oq_cut.pop_front());
   endtask
   task t_regs();
      logic [31:0] q;
      logic e;
      apb(1'b0, OFS_CTRL, 32'h0, q, e);
      chk("ctrl reset", CTRL_RESET, q);
      apb(1'b0, 8'h44, 32'h0, q, e);
      chk("unmapped err", 32'h1, e);
      chk("unmapped data", 32'h0, q);
      apb(1'b0, OFS_CMD, 32'h0, q, e);
      chk("cmd read", 32'h0, q);
   endtask
   task t_seq();
      logic [HANDLE_W-1:0] h0, h1, x0;
      logic [31:0] q;
      logic e;
      wr(OFS_START, 32'h2);
      wr(OFS_VCOUNT, 32'h2);
      wr(OFS_ICOUNT, 32'h1);
      wr(OFS_ARRBASE0, 32'h100);
      wr(OFS_MAXIDX0, 32'h2);
      wr(OFS_ELEM0, EL_A);
      draw(3);
      pop_vtx(32'h5a00_0009, 32'h0, 32'h0, h0);
      pop_vtx(32'h0, 32'h1, 32'h0, h1);
      pop_cut();
      draw(3);
      pop_hit(h0, 32'h0);
      pop_hit(h1, 32'h0);
      pop_cut();
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      chk("hit count", 32'h0002_0000, q);
      wr(OFS_BASE, 32'h0);
      draw(3);
      pop_vtx(32'h5a00_0009, 32'h0, 32'h0, x0);
      pop_vtx(32'h0, 32'h1, 32'h0, x0);
      pop_cut();
      chk("stray writes", 32'h0, wq_dw.size());
   endtask
   task t_inst();
      logic [HANDLE_W-1:0] h;
      wr(OFS_START, 32'h0);
      wr(OFS_VCOUNT, 32'h1);
      wr(OFS_ICOUNT, 32'h2);
      wr(OFS_MAXIDX0, 32'h8);
      wr(OFS_ELEM0, EL_A | 32'h4);
      draw(4);
      pop_vtx(32'h5a00_0001, 32'h0, 32'h0, h);
      pop_cut();
      pop_vtx(32'h5a00_0005, 32'h0, 32'h0, h);
      pop_cut();
   endtask
   task t_rand();
      logic [HANDLE_W-1:0] h0, h1;
      wr(OFS_ICOUNT, 32'h1);
      wr(OFS_VCOUNT, 32'h4);
      wr(OFS_ELEM0, EL_A);
      wr(OFS_IDXBASE, 32'h40);
      for (int ce = 1; ce >= 0; ce--)
      begin
         wr(OFS_CTRL, 32'h6 | 32'(ce));
         draw(5);
         pop_vtx(32'h5a00_0015, 32'h5, 32'h0, h0);
         if (ce == 1)
            pop_hit(h0, 32'h0);
         else
            pop_vtx(32'h5a00_0015, 32'h5, 32'h0, h1);
         pop_cut();
         if (ce == 1)
            pop_hit(h0, 32'h1);
         else
            pop_vtx(32'h5a00_0015, 32'h5, 32'h1, h1);
         pop_cut();
      end
   endtask
   initial
   begin
      #200000;
      errors++;
      wrap_up();
   end
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      // index words after the model's own fill: upper bits masked at 8-bit width, 0xff cuts
      i_via_mem_model.mem[8'h40] = 32'h0000_0005;
      i_via_mem_model.mem[8'h41] = 32'h0000_0105;
      i_via_mem_model.mem[8'h42] = 32'h0000_00ff;
      i_via_mem_model.mem[8'h43] = 32'h0000_0005;
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_seq();
      t_inst();
      t_rand();
      wrap_up();
   end
endmodule
`default_nettype wire
